// >>> include/fmc_pkg.sv
package fmc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TX_TO_S_SHORT = 1;
  localparam int unsigned TX_TO_S_LONG = 3;
  localparam int unsigned TO_OFF_MS = 125;
  localparam int unsigned WD_TO_MS = 1490;
  localparam int unsigned CD_US_0 = 500;
  localparam int unsigned CD_MS_1 = 1;
  localparam int unsigned CD_MS_2 = 3;
  localparam int unsigned CD_MS_3 = 5;
  localparam int unsigned BAUD_0 = 600;
  localparam int unsigned BAUD_1 = 1200;
  localparam int unsigned BAUD_2 = 2400;
  localparam int unsigned BAUD_3 = 4800;
  localparam int unsigned MIN_SEP_HZ = 600;
  // cycle counts derived from times and baud rates
  localparam int unsigned TX_TO_CYC_SHORT = TX_TO_S_SHORT * CLK_HZ;
  localparam int unsigned TX_TO_CYC_LONG = TX_TO_S_LONG * CLK_HZ;
  localparam int unsigned TO_OFF_CYC = TO_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_TO_CYC = WD_TO_MS * (CLK_HZ / 1000);
  localparam int unsigned CD_CYC_0 = CD_US_0 * (CLK_HZ / 1_000_000);
  localparam int unsigned CD_CYC_1 = CD_MS_1 * (CLK_HZ / 1000);
  localparam int unsigned CD_CYC_2 = CD_MS_2 * (CLK_HZ / 1000);
  localparam int unsigned CD_CYC_3 = CD_MS_3 * (CLK_HZ / 1000);
  localparam int unsigned BIT_CYC_0 = CLK_HZ / BAUD_0;
  localparam int unsigned BIT_CYC_1 = CLK_HZ / BAUD_1;
  localparam int unsigned BIT_CYC_2 = CLK_HZ / BAUD_2;
  localparam int unsigned BIT_CYC_3 = CLK_HZ / BAUD_3;
  // reset values and mclk divider codes
  localparam logic [2:0] RST_CHANNEL = 3'h7;
  localparam logic [1:0] RST_BAUD = 2'h2;
  localparam logic RST_DEV_ONE = 1'b0;
  localparam logic [1:0] MCLK_DIV2 = 2'h0;
  localparam logic [1:0] MCLK_DIV4 = 2'h1;
  localparam logic [1:0] RST_MCLK = 2'h0;
  localparam logic [1:0] RST_TO_SEL = 2'h1;
  localparam logic [1:0] RST_CD_SEL = 2'h0;
  // carrier frequencies in Hz/10
  localparam logic [15:0] CARRIER_0 = 16'h1770;
  localparam logic [15:0] CARRIER_1 = 16'h19C8;
  localparam logic [15:0] CARRIER_2 = 16'h1C20;
  localparam logic [15:0] CARRIER_3 = 16'h1DB0;
  localparam logic [15:0] CARRIER_4 = 16'h200D;
  localparam logic [15:0] CARRIER_5 = 16'h2198;
  localparam logic [15:0] CARRIER_6 = 16'h2AF8;
  localparam logic [15:0] CARRIER_7 = 16'h33C2;

  typedef struct packed {
    logic [2:0] channel;
    logic [1:0] baud_sel;
    logic       dev_one;
    logic [1:0] to_sel;
    logic [1:0] cd_sel;
    logic [1:0] mclk_sel;
    logic       sync_mode;
  } fmc_cfg_t;

  typedef struct packed {
    logic [17:0] mark_hz;
    logic [17:0] space_hz;
    logic [2:0]  rx_channel;
    logic [2:0]  tx_channel;
  } fmc_tune_t;

  typedef enum logic [1:0] {
    FMC_IDLE    = 2'b00,
    FMC_SEND    = 2'b01,
    FMC_TIMEOUT = 2'b11,
    FMC_HOLD    = 2'b10
  } fmc_tx_state_t;
endpackage

// >>> design/fmc_skid_buf.sv
`timescale 1ns/1ns
module fmc_skid_buf #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  logic [WIDTH-1:0] mem [2];
  logic [WIDTH-1:0] next_mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             next_wr_ptr;
  logic             next_rd_ptr;
  logic [1:0]       next_count;
  logic             push;
  logic             pop;

  always_comb begin
    push = i_valid && (count != 2'h2);
    pop = (count != 2'h0) && i_ready;
    next_mem = mem;
    if (push) begin
      next_mem[wr_ptr] = i_data;
    end
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data = mem[rd_ptr];
endmodule

// >>> design/fmc_core.sv
`timescale 1ns/1ns
module fmc_core #(
  parameter int unsigned TX_TO_CYC_SHORT = fmc_pkg::TX_TO_CYC_SHORT,
  parameter int unsigned TX_TO_CYC_LONG  = fmc_pkg::TX_TO_CYC_LONG,
  parameter int unsigned TO_OFF_CYC      = fmc_pkg::TO_OFF_CYC,
  parameter int unsigned WD_TO_CYC       = fmc_pkg::WD_TO_CYC,
  parameter int unsigned CD_CYC_1        = fmc_pkg::CD_CYC_1,
  parameter int unsigned CD_CYC_2        = fmc_pkg::CD_CYC_2,
  parameter int unsigned CD_CYC_3        = fmc_pkg::CD_CYC_3
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire fmc_pkg::fmc_cfg_t i_cfg,
  input  wire logic              i_cfg_load,
  input  wire logic              i_direction_select,
  input  wire logic              i_tx_bit,
  input  wire logic              i_carrier_raw,
  input  wire logic              i_watchdog,
  input  wire logic              i_mod_ready,
  output fmc_pkg::fmc_tune_t     o_tune,
  output logic                   o_bit_clock_line,
  output logic                   o_mod_valid,
  output logic                   o_mod_bit,
  output logic                   o_tx_timeout,
  output logic                   o_carrier_detect_flag_n,
  output logic                   o_mclk,
  output logic                   o_wd_timeout
);
  fmc_pkg::fmc_cfg_t cfg;
  fmc_pkg::fmc_cfg_t next_cfg;
  logic [17:0] carrier_hz;
  logic [17:0] sep_hz;
  fmc_pkg::fmc_tune_t next_tune;
  logic [14:0] bit_cyc;
  logic [14:0] bit_cnt;
  logic [14:0] next_bit_cnt;
  logic        tick;
  logic        next_bclk;
  logic        next_mod_bit;
  logic        feed_valid;
  logic        feed_ready;
  fmc_pkg::fmc_tx_state_t tx_state;
  fmc_pkg::fmc_tx_state_t next_tx_state;
  logic [31:0] tx_cnt;
  logic [31:0] next_tx_cnt;
  logic [31:0] to_limit;
  logic [31:0] cd_limit;
  logic [31:0] cd_cnt;
  logic [31:0] next_cd_cnt;
  logic        next_cd_n;
  logic [31:0] wd_cnt;
  logic [31:0] next_wd_cnt;
  logic        wd_prev;
  logic        next_wd_to;
  logic [1:0]  div_cnt;
  logic        next_mclk;

  ////////////////////////////////////////////////////////////////////////////
  // configuration and tone synthesis
  always_comb begin
    next_cfg = cfg;
    if (i_cfg_load) begin
      next_cfg = i_cfg;
      if (i_cfg.baud_sel == 2'h0) begin
        next_cfg.dev_one = 1'b1;
      end
    end
    unique case (cfg.channel)
      3'h0: carrier_hz = 18'(fmc_pkg::CARRIER_0 * 10);
      3'h1: carrier_hz = 18'(fmc_pkg::CARRIER_1 * 10);
      3'h2: carrier_hz = 18'(fmc_pkg::CARRIER_2 * 10);
      3'h3: carrier_hz = 18'(fmc_pkg::CARRIER_3 * 10);
      3'h4: carrier_hz = 18'(fmc_pkg::CARRIER_4 * 10);
      3'h5: carrier_hz = 18'(fmc_pkg::CARRIER_5 * 10);
      3'h6: carrier_hz = 18'(fmc_pkg::CARRIER_6 * 10);
      3'h7: carrier_hz = 18'(fmc_pkg::CARRIER_7 * 10);
    endcase
    unique case (cfg.baud_sel)
      2'h0: begin
        sep_hz = 18'(fmc_pkg::BAUD_0);
        bit_cyc = 15'(fmc_pkg::BIT_CYC_0);
      end
      2'h1: begin
        sep_hz = 18'(fmc_pkg::BAUD_1);
        bit_cyc = 15'(fmc_pkg::BIT_CYC_1);
      end
      2'h2: begin
        sep_hz = 18'(fmc_pkg::BAUD_2);
        bit_cyc = 15'(fmc_pkg::BIT_CYC_2);
      end
      2'h3: begin
        sep_hz = 18'(fmc_pkg::BAUD_3);
        bit_cyc = 15'(fmc_pkg::BIT_CYC_3);
      end
    endcase
    if (!cfg.dev_one) begin
      sep_hz = sep_hz >> 1;
    end
    if (sep_hz < 18'(fmc_pkg::MIN_SEP_HZ)) begin
      sep_hz = 18'(fmc_pkg::MIN_SEP_HZ);
    end
    next_tune.space_hz = carrier_hz + (sep_hz >> 1);
    next_tune.mark_hz = carrier_hz - (sep_hz >> 1);
    next_tune.rx_channel = cfg.channel;
    next_tune.tx_channel = cfg.channel;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cfg <= '{channel: fmc_pkg::RST_CHANNEL, baud_sel: fmc_pkg::RST_BAUD,
               dev_one: fmc_pkg::RST_DEV_ONE, to_sel: fmc_pkg::RST_TO_SEL,
               cd_sel: fmc_pkg::RST_CD_SEL, mclk_sel: fmc_pkg::RST_MCLK,
               sync_mode: 1'b1};
    end else begin
      cfg <= next_cfg;
    end
    // tracks config through reset so no all-zero tone pair follows it
    o_tune <= next_tune;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit clock and synchronous transmit sampling
  always_comb begin
    tick = (bit_cnt >= bit_cyc - 15'h1);
    next_bit_cnt = tick ? 15'h0 : bit_cnt + 15'h1;
    next_bclk = (bit_cnt < (bit_cyc >> 1));
    // sample on rising bit clock
    // first edge that sees the line high, as the host does; no feed once aborted
    feed_valid = cfg.sync_mode && (bit_cnt == 15'h1) && !i_direction_select && !o_tx_timeout;
    next_mod_bit = i_tx_bit;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      bit_cnt <= 15'h0;
      o_bit_clock_line <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      o_bit_clock_line <= next_bclk;
    end
  end

  // two entries so a modulator stall keeps the sampled bit
  fmc_skid_buf #(.WIDTH(1)) u_buf (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_valid    (feed_valid),
    .o_ready    (feed_ready),
    .i_data     (next_mod_bit),
    .o_valid    (o_mod_valid),
    .i_ready    (i_mod_ready),
    .o_data     (o_mod_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmit time-out
  always_comb begin
    to_limit = (cfg.to_sel == 2'h2) ? TX_TO_CYC_LONG : TX_TO_CYC_SHORT;
    next_tx_state = tx_state;
    next_tx_cnt = tx_cnt + 32'h1;
    unique case (tx_state)
      fmc_pkg::FMC_IDLE: begin
        next_tx_cnt = 32'h0;
        if (!i_direction_select && cfg.to_sel != 2'h0) begin
          next_tx_state = fmc_pkg::FMC_SEND;
        end
      end
      fmc_pkg::FMC_SEND: begin
        if (i_direction_select) begin
          next_tx_state = fmc_pkg::FMC_IDLE;
        end else if (tx_cnt >= to_limit - 32'h1) begin
          next_tx_state = fmc_pkg::FMC_TIMEOUT;
          next_tx_cnt = 32'h0;
        end
      end
      fmc_pkg::FMC_TIMEOUT: begin
        if (tx_cnt >= TO_OFF_CYC - 1) begin
          next_tx_state = fmc_pkg::FMC_HOLD;
        end
      end
      fmc_pkg::FMC_HOLD: begin
        next_tx_cnt = 32'h0;
        if (i_direction_select) begin
          next_tx_state = fmc_pkg::FMC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tx_state <= fmc_pkg::FMC_IDLE;
      tx_cnt <= 32'h0;
    end else begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
    end
  end

  assign o_tx_timeout = (tx_state == fmc_pkg::FMC_TIMEOUT) || (tx_state == fmc_pkg::FMC_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // carrier detect qualification
  always_comb begin
    unique case (cfg.cd_sel)
      2'h0: cd_limit = fmc_pkg::CD_CYC_0;
      2'h1: cd_limit = CD_CYC_1;
      2'h2: cd_limit = CD_CYC_2;
      2'h3: cd_limit = CD_CYC_3;
    endcase
    next_cd_n = o_carrier_detect_flag_n;
    next_cd_cnt = 32'h0;
    if (i_carrier_raw == o_carrier_detect_flag_n) begin
      next_cd_cnt = cd_cnt + 32'h1;
      if (cd_cnt >= cd_limit - 32'h1) begin
        next_cd_n = ~i_carrier_raw;
        next_cd_cnt = 32'h0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cd_cnt <= 32'h0;
      o_carrier_detect_flag_n <= 1'b1;
    end else begin
      cd_cnt <= next_cd_cnt;
      o_carrier_detect_flag_n <= next_cd_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog and master clock output
  always_comb begin
    next_wd_cnt = (wd_cnt >= WD_TO_CYC) ? wd_cnt : wd_cnt + 32'h1;
    next_wd_to = o_wd_timeout;
    if (i_watchdog && !wd_prev) begin
      next_wd_cnt = 32'h0;
      next_wd_to = 1'b0;
    end
    // expiry beats a service edge in the same cycle
    if (wd_cnt == WD_TO_CYC - 1) begin
      next_wd_to = 1'b1;
    end
    // divide by two or four, else off
    unique case (cfg.mclk_sel)
      fmc_pkg::MCLK_DIV2: next_mclk = ~div_cnt[0];
      fmc_pkg::MCLK_DIV4: next_mclk = div_cnt[1];
      default:            next_mclk = 1'b0;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wd_cnt <= 32'h0;
      wd_prev <= 1'b0;
      o_wd_timeout <= 1'b0;
      div_cnt <= 2'h0;
      o_mclk <= 1'b0;
    end else begin
      wd_cnt <= next_wd_cnt;
      wd_prev <= i_watchdog;
      o_wd_timeout <= next_wd_to;
      div_cnt <= div_cnt + 2'h1;
      o_mclk <= next_mclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_tone_order;
    @(posedge i_core_clk) disable iff (i_rst)
      o_tune.space_hz > o_tune.mark_hz;
  endproperty
  a_tone_order: assert property (p_tone_order) else $error("space not above mark");

  property p_min_sep;
    @(posedge i_core_clk) disable iff (i_rst)
      (o_tune.space_hz - o_tune.mark_hz) >= 18'(fmc_pkg::MIN_SEP_HZ);
  endproperty
  a_min_sep: assert property (p_min_sep) else $error("separation too small");

  property p_600_dev;
    @(posedge i_core_clk) disable iff (i_rst)
      cfg.baud_sel == 2'h0 |-> cfg.dev_one;
  endproperty
  a_600_dev: assert property (p_600_dev) else $error("half deviation at 600");

  property p_same_chan;
    @(posedge i_core_clk) disable iff (i_rst)
      o_tune.rx_channel == $past(cfg.channel) && o_tune.tx_channel == $past(cfg.channel);
  endproperty
  a_same_chan: assert property (p_same_chan) else $error("filters on different channels");

  property p_to_release;
    @(posedge i_core_clk) disable iff (i_rst)
      (tx_state == fmc_pkg::FMC_HOLD && i_direction_select) |=> ##[0:1] !o_tx_timeout;
  endproperty
  a_to_release: assert property (p_to_release) else $error("time-out not released");

  property p_to_hold;
    @(posedge i_core_clk) disable iff (i_rst)
      $rose(o_tx_timeout) |-> o_tx_timeout [*8];
  endproperty
  a_to_hold: assert property (p_to_hold) else $error("time-out dropped early");

  property p_wd_fire;
    @(posedge i_core_clk) disable iff (i_rst)
      (wd_cnt == WD_TO_CYC - 1) |=> o_wd_timeout;
  endproperty
  a_wd_fire: assert property (p_wd_fire) else $error("watchdog missed");

  property p_bclk_period;
    @(posedge i_core_clk) disable iff (i_rst)
      tick |=> bit_cnt == 15'h0 ##1 o_bit_clock_line;
  endproperty
  a_bclk_period: assert property (p_bclk_period) else $error("bit clock off period");

  property p_sample_edge;
    @(posedge i_core_clk) disable iff (i_rst)
      feed_valid |-> o_bit_clock_line && !$past(o_bit_clock_line);
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("sample off bit clock rise");

  property p_sync_sample;
    @(posedge i_core_clk) disable iff (i_rst)
      (feed_valid && feed_ready && i_mod_ready && !o_mod_valid) |=> o_mod_valid;
  endproperty
  a_sync_sample: assert property (p_sync_sample) else $error("sampled bit lost");

  property p_mclk_off;
    @(posedge i_core_clk) disable iff (i_rst)
      (cfg.mclk_sel == 2'h2) [*2] |-> !o_mclk;
  endproperty
  a_mclk_off: assert property (p_mclk_off) else $error("mclk not off");
endmodule

// >>> sim/fmc_host_model.sv
`timescale 1ns/1ns
module fmc_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_bit_clock_line,
  input  wire logic i_wd_en,
  output logic      o_tx_bit,
  output logic      o_watchdog
);
  int   seed;
  int   wd_cnt;
  logic clk_q;
  initial begin
    seed = 90383;
    wd_cnt = 0;
    clk_q = 1'b0;
    o_tx_bit = 1'b0;
    o_watchdog = 1'b0;
  end
  // change data mid-bit
  // changing on the falling edge keeps the bit stable around the sampling rise
  always @(posedge i_core_clk) begin
    clk_q <= i_bit_clock_line;
    if (clk_q && !i_bit_clock_line)
      o_tx_bit <= 1'($random(seed));
  end
  always @(posedge i_core_clk) begin
    wd_cnt <= (wd_cnt == 999) ? 0 : wd_cnt + 1;
    o_watchdog <= !i_rst && i_wd_en && (wd_cnt < 2);
  end
endmodule

// >>> sim/fsk_modem_config_timing_tb.sv
`timescale 1ns/1ns
module fsk_modem_config_timing_tb;
  localparam int SHORT = 1000;
  localparam int LONG = 3000;
  localparam int OFF = 300;
  localparam int WD = 3000;
  localparam logic [15:0] CAR [8] = '{fmc_pkg::CARRIER_0, fmc_pkg::CARRIER_1,
    fmc_pkg::CARRIER_2, fmc_pkg::CARRIER_3, fmc_pkg::CARRIER_4, fmc_pkg::CARRIER_5,
    fmc_pkg::CARRIER_6, fmc_pkg::CARRIER_7};
  localparam int BAUD [4] = '{fmc_pkg::BAUD_0, fmc_pkg::BAUD_1, fmc_pkg::BAUD_2,
    fmc_pkg::BAUD_3};
  localparam int BITC [4] = '{fmc_pkg::BIT_CYC_0, fmc_pkg::BIT_CYC_1,
    fmc_pkg::BIT_CYC_2, fmc_pkg::BIT_CYC_3};
  localparam int CDC [4] = '{fmc_pkg::CD_CYC_0, 20, 40, 60};
  localparam int TOL [4] = '{0, SHORT, LONG, SHORT};

  logic               clk;
  logic               rst;
  fmc_pkg::fmc_cfg_t  cfg;
  fmc_pkg::fmc_cfg_t  c;
  logic               cfg_load;
  logic               dir;
  logic               tx_bit;
  logic               carrier;
  logic               wd;
  logic               mod_ready;
  fmc_pkg::fmc_tune_t tune;
  logic               bclk;
  logic               mod_valid;
  logic               mod_bit;
  logic               tx_to;
  logic               cd_n;
  logic               mclk;
  logic               wd_to;
  logic               wd_en;
  logic               cap_en;
  logic               bq;
  logic               q_full;
  logic               m;
  logic               q [$];
  int                 failures;
  int                 n_checks;
  int                 seed;
  int                 pops;
  int                 n;
  int                 k;

  fmc_core #(.TX_TO_CYC_SHORT(SHORT), .TX_TO_CYC_LONG(LONG), .TO_OFF_CYC(OFF),
    .WD_TO_CYC(WD), .CD_CYC_1(20), .CD_CYC_2(40), .CD_CYC_3(60)) u_dut (
    .i_core_clk(clk), .i_rst(rst), .i_cfg(cfg), .i_cfg_load(cfg_load),
    .i_direction_select(dir), .i_tx_bit(tx_bit), .i_carrier_raw(carrier),
    .i_watchdog(wd), .i_mod_ready(mod_ready), .o_tune(tune), .o_bit_clock_line(bclk),
    .o_mod_valid(mod_valid), .o_mod_bit(mod_bit), .o_tx_timeout(tx_to),
    .o_carrier_detect_flag_n(cd_n), .o_mclk(mclk), .o_wd_timeout(wd_to));

  fmc_host_model u_host (
    .i_core_clk(clk), .i_rst(rst), .i_bit_clock_line(bclk), .i_wd_en(wd_en),
    .o_tx_bit(tx_bit), .o_watchdog(wd));

  ////////////////////////////////////////////////////////////////////////////
  function automatic fmc_pkg::fmc_tune_t exp_tune(input fmc_pkg::fmc_cfg_t x);
    int                 sep;
    int                 car;
    fmc_pkg::fmc_tune_t t;
    sep = (x.dev_one || x.baud_sel == 2'h0) ? BAUD[x.baud_sel] : BAUD[x.baud_sel] / 2;
    car = CAR[x.channel] * 10;
    t.mark_hz = 18'(car - sep / 2);
    t.space_hz = 18'(car + sep / 2);
    t.rx_channel = x.channel;
    t.tx_channel = x.channel;
    return t;
  endfunction

  function automatic logic sig(input int w);
    case (w)
      0: return tx_to;
      1: return cd_n;
      2: return wd_to;
      default: return bclk;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      failures++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int x);
    repeat (x) @(posedge clk);
    #1;
  endtask

  task automatic wait_sig(input int w, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (sig(w) !== v && cnt <= lim) begin
      cyc(1);
      cnt++;
    end
    if (cnt > lim) begin
      failures++;
      $display("mismatch wait expected %0d seen %0d", lim, cnt);
      results();
    end
  endtask

  task automatic load(input fmc_pkg::fmc_cfg_t x);
    @(posedge clk);
    cfg <= x;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    cyc(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // fullness judged before the pop, as the buffer does; a full buffer drops the new bit
  always @(posedge clk) begin
    bq <= bclk;
    q_full = (q.size() == 2);
    if (mod_valid === 1'b1 && mod_ready === 1'b1) begin
      pops++;
      if (q.size() == 0)
        chk("mod_extra", 0, 1);
      else
        chk("mod_bit", q.pop_front(), mod_bit);
    end
    if (cap_en && bclk === 1'b1 && bq === 1'b0 && !q_full)
      q.push_back(tx_bit);
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rst = 1'b1; cfg = '0; cfg_load = 1'b0; dir = 1'b1; carrier = 1'b0;
    mod_ready = 1'b1; wd_en = 1'b1; cap_en = 1'b0; bq = 1'b0; q_full = 1'b0;
    failures = 0; n_checks = 0; seed = 90383; pops = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    c = '0;
    c.channel = fmc_pkg::RST_CHANNEL;
    c.baud_sel = fmc_pkg::RST_BAUD;
    c.dev_one = fmc_pkg::RST_DEV_ONE;
    chk("tune_rst", exp_tune(c), tune);
    chk("cd_rst", 1, cd_n);
    chk("to_rst", 0, tx_to);
    for (int i = 0; i < 16; i++) begin
      c = 13'($random(seed));
      c.channel = 3'(i);
      c.baud_sel = 2'(i >> 2);
      c.dev_one = i[0];
      load(c);
      chk("tune", exp_tune(c), tune);
      @(posedge clk);
      cfg <= ~c;
      cyc(4);
      chk("tune_hold", exp_tune(c), tune);
    end
    c = '0;
    for (int s = 0; s < 4; s++) begin
      c.mclk_sel = 2'(s);
      load(c);
      k = 0;
      m = mclk;
      repeat (16) begin
        cyc(1);
        if (mclk !== m)
          k++;
        m = mclk;
      end
      chk("mclk", (s == 0) ? 16 : (s == 1) ? 8 : 0, k);
    end
    for (int s = 0; s < 4; s++) begin
      c.cd_sel = 2'(s);
      load(c);
      @(posedge clk);
      carrier <= 1'b1;
      wait_sig(1, 1'b0, CDC[s] + 20, n);
      chk_rng("cd_on", CDC[s] - 3, CDC[s] + 3, n);
      @(posedge clk);
      carrier <= 1'b0;
      wait_sig(1, 1'b1, CDC[s] + 20, n);
      chk_rng("cd_off", 0, CDC[s] + 3, n);
    end
    c.sync_mode = 1'b1;
    for (int s = 0; s < 4; s++) begin
      c.baud_sel = 2'(s);
      load(c);
      wait_sig(3, 1'b0, 2 * BITC[s], n);
      wait_sig(3, 1'b1, 2 * BITC[s], n);
      wait_sig(3, 1'b0, BITC[s], n);
      wait_sig(3, 1'b1, BITC[s], k);
      chk_rng("bit_time", BITC[s] - 2, BITC[s] + 2, n + k);
    end
    // stall in mid-stream so the buffer fills and refuses
    @(posedge clk);
    dir <= 1'b0;
    cap_en <= 1'b1;
    for (k = 0; k < 6 * BITC[3]; k++) begin
      @(posedge clk);
      mod_ready <= (k < 2 * BITC[3] || k > 5 * BITC[3]) ? 1'($random(seed)) : 1'b0;
    end
    @(posedge clk);
    cap_en <= 1'b0;
    mod_ready <= 1'b1;
    dir <= 1'b1;
    cyc(10);
    chk("drained", 0, q.size());
    chk_rng("pops", 4, 8, pops);
    c.sync_mode = 1'b0;
    for (int s = 0; s < 4; s++) begin
      c.to_sel = 2'(s);
      load(c);
      @(posedge clk);
      dir <= 1'b0;
      if (s == 0) begin
        cyc(LONG + 100);
        chk("to_off", 0, tx_to);
      end else begin
        wait_sig(0, 1'b1, TOL[s] + 20, n);
        chk_rng("to_time", TOL[s] - 2, TOL[s] + 3, n);
      end
      // host clears by going to receive
      @(posedge clk);
      dir <= 1'b1;
      wait_sig(0, 1'b0, OFF + 20, n);
      if (s != 0)
        chk_rng("to_hold", OFF - 3, OFF + 3, n);
    end
    chk("wd_ok", 0, wd_to);
    @(posedge clk);
    wd_en <= 1'b0;
    wait_sig(2, 1'b1, WD + 20, n);
    chk_rng("wd_time", WD - 1005, WD + 3, n);
    @(posedge clk);
    wd_en <= 1'b1;
    wait_sig(2, 1'b0, 1010, n);
    chk("wd_clear", 0, wd_to);
    results();
  end
endmodule
